/* design/aontpg_pkg.sv */
// Package with register layout, reset values and bus constants for the two-pin control block.
package aontpg_pkg;

   // ------------------------------------------------------------
   // Bus geometry
   // ------------------------------------------------------------
   localparam int unsigned ADR_W = 8;
   localparam int unsigned DATA_W = 32;
   localparam logic [7:0] CTRL_OFFSET = 8'h20;

   // ------------------------------------------------------------
   // Field layout of one pin nibble
   // ------------------------------------------------------------
   localparam int unsigned PIN_STRIDE = 4;
   localparam int unsigned FLD_LEVEL = 0;
   localparam int unsigned FLD_DRIVE = 1;
   localparam int unsigned FLD_PULL = 2;
   localparam int unsigned FLD_IN = 3;
   localparam int unsigned CTRL_W = 3;
   localparam logic [2:0] CTRL_RESET = 3'h0;

   // ------------------------------------------------------------
   // Supply monitor reset values
   // ------------------------------------------------------------
   localparam logic SUPPLY_OK_RESET = 1'h0;
   localparam logic PAD_RST_RESET = 1'h1;

endpackage

/* design/aontpg_sync.sv */
// Two-flop synchroniser for a group of asynchronous level inputs.
`timescale 1ns/100ps
module aontpg_sync #(
   parameter int unsigned WIDTH = 2
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_q
);

   // ------------------------------------------------------------
   // One pair of flops per bit.
   // ------------------------------------------------------------
   generate
      if (WIDTH < 1) begin : g_bad_width
         $error("Synchroniser width must be at least one.");
      end
      for (genvar b = 0; b < WIDTH; b++) begin : g_bit
         logic meta_q;
         always_ff @(posedge clk or posedge reset) begin
            if (reset) begin
               meta_q <= 1'h0;
               sync_q[b] <= 1'h0;
            end else begin
               meta_q <= async_in[b];
               sync_q[b] <= meta_q;
            end
         end
      end
   endgenerate

endmodule

/* design/aontpg_supply_reset.sv */
// Supply monitor reset generator for the pad logic and the always-on register domain.
`timescale 1ns/100ps
module aontpg_supply_reset (
   input wire logic clk,
   input wire logic reset,
   input wire logic io_supply_low_ok,
   input wire logic io_supply_high_ok,
   input wire logic aon_supply_ok,
   output logic pad_rst_q,
   output logic domain_rst_q
);

   // ------------------------------------------------------------
   // Synchronise the monitor levels, then derive the resets.
   // ------------------------------------------------------------
   logic [2:0] meta_q;
   logic [2:0] ok_q;
   logic pad_rst_d;
   logic domain_rst_d;

   always_comb begin
      pad_rst_d = ~(ok_q[0] & ok_q[1]); // [R10] [R11]
      domain_rst_d = ~ok_q[2]; // [R9]
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         meta_q <= {3{aontpg_pkg::SUPPLY_OK_RESET}};
         ok_q <= {3{aontpg_pkg::SUPPLY_OK_RESET}};
         pad_rst_q <= aontpg_pkg::PAD_RST_RESET;
         domain_rst_q <= aontpg_pkg::PAD_RST_RESET;
      end else begin
         meta_q <= {aon_supply_ok, io_supply_high_ok, io_supply_low_ok};
         ok_q <= meta_q;
         pad_rst_q <= pad_rst_d;
         domain_rst_q <= domain_rst_d;
      end
   end

endmodule

/* design/aontpg_top.sv */
// Two-pin always-on pin control register with a classic Wishbone slave.
//
// The Wishbone register port was left to the implementer.
`timescale 1ns/100ps

// Operation
// R1: Bit 7 reads the synchronised level of pin 1.
// R2: Bit 6 enables the pin 1 pull-up; resets to 0.
// R3: Bit 5 makes pin 1 an output; resets to 0.
// R4: Bit 4 is the pin 1 driven level, used only while bit 5 is set.
// R5: Bit 3 reads the synchronised level of pin 0.
// R6: Bit 2 enables the pin 0 pull-up; resets to 0.
// R7: Bit 1 makes pin 0 an output; resets to 0.
// R8: Bit 0 is the pin 0 driven level, used only while bit 1 is set.
// R9: A failing always-on supply resets every register of the domain.
// R10: Pad logic stays in reset until both I/O supplies are good.
// R11: A failing I/O supply forces the pad logic back into reset.
// R12: Bits 31 to 8 read as zero and ignore writes.
// R13: Pin levels pass two flops before reaching the status bits.
module aontpg_top #(
   parameter int unsigned PINS = 2
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [aontpg_pkg::ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [aontpg_pkg::DATA_W-1:0] wb_dat_i,
   output logic [aontpg_pkg::DATA_W-1:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic [PINS-1:0] aon_pin_in,
   output logic [PINS-1:0] aon_pin_out,
   output logic [PINS-1:0] aon_pin_oe_n,
   output logic [PINS-1:0] aon_pin_pullup,
   input wire logic io_supply_low_ok,
   input wire logic io_supply_high_ok,
   input wire logic aon_supply_ok
);

   // ------------------------------------------------------------
   // Elaboration check
   // ------------------------------------------------------------
   generate
      if (PINS < 1 || PINS > 2) begin : g_bad_pins
         $error("The control register holds one or two pins only.");
      end
   endgenerate

   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   logic [PINS-1:0] pin_s;
   logic pad_rst;
   logic domain_rst;
   logic soft_rst;
   logic req;
   logic hit;
   logic wr_fire;
   logic ack_q;
   logic ack_d;
   logic [aontpg_pkg::DATA_W-1:0] dat_q;
   logic [aontpg_pkg::DATA_W-1:0] dat_d;
   logic [aontpg_pkg::DATA_W-1:0] rd_word;
   logic [PINS-1:0][aontpg_pkg::CTRL_W-1:0] ctrl_q;
   logic [PINS-1:0][aontpg_pkg::CTRL_W-1:0] ctrl_d;
   logic [PINS-1:0] out_q;
   logic [PINS-1:0] out_d;
   logic [PINS-1:0] oe_n_q;
   logic [PINS-1:0] oe_n_d;
   logic [PINS-1:0] pull_q;
   logic [PINS-1:0] pull_d;

   // ------------------------------------------------------------
   // Input synchroniser and supply resets
   // ------------------------------------------------------------
   aontpg_sync #(
      .WIDTH(PINS)
   ) u_pin_sync (
      .clk(clk),
      .reset(reset),
      .async_in(aon_pin_in),
      .sync_q(pin_s)
   );

   aontpg_supply_reset u_supply (
      .clk(clk),
      .reset(reset),
      .io_supply_low_ok(io_supply_low_ok),
      .io_supply_high_ok(io_supply_high_ok),
      .aon_supply_ok(aon_supply_ok),
      .pad_rst_q(pad_rst),
      .domain_rst_q(domain_rst)
   );

   assign soft_rst = pad_rst | domain_rst;

   // ------------------------------------------------------------
   // Read word assembly
   // ------------------------------------------------------------
   generate
      for (genvar p = 0; p < PINS; p++) begin : g_word
         assign rd_word[aontpg_pkg::PIN_STRIDE*p+aontpg_pkg::FLD_IN] = pin_s[p]; // [R1] [R5] [R13]
         assign rd_word[aontpg_pkg::PIN_STRIDE*p +: aontpg_pkg::CTRL_W] = ctrl_q[p];
      end
   endgenerate
   assign rd_word[aontpg_pkg::DATA_W-1:aontpg_pkg::PIN_STRIDE*PINS] = '0; // [R12]

   // ------------------------------------------------------------
   // Wishbone slave and control register
   // ------------------------------------------------------------
   always_comb begin
      req = wb_cyc_i & wb_stb_i & ~ack_q;
      hit = wb_adr_i[aontpg_pkg::ADR_W-1:2] == aontpg_pkg::CTRL_OFFSET[aontpg_pkg::ADR_W-1:2];
      wr_fire = req & wb_we_i & hit & wb_sel_i[0];
      ack_d = req;
      dat_d = '0;
      if (req && !wb_we_i && hit) begin
         dat_d = rd_word;
      end
      ctrl_d = ctrl_q;
      if (soft_rst) begin
         ctrl_d = '0; // [R9] [R10] [R11]
      end else if (wr_fire) begin
         for (int p = 0; p < PINS; p++) begin
            ctrl_d[p] = wb_dat_i[aontpg_pkg::PIN_STRIDE*p +: aontpg_pkg::CTRL_W]; // [R2] [R3] [R4] [R6] [R7] [R8]
         end
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         ack_q <= 1'h0;
         dat_q <= '0;
         ctrl_q <= {PINS{aontpg_pkg::CTRL_RESET}};
      end else begin
         ack_q <= ack_d;
         dat_q <= dat_d;
         ctrl_q <= ctrl_d;
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = dat_q;

   // ------------------------------------------------------------
   // Pad drivers
   // ------------------------------------------------------------
   always_comb begin
      for (int p = 0; p < PINS; p++) begin
         oe_n_d[p] = ~(ctrl_q[p][aontpg_pkg::FLD_DRIVE] & ~pad_rst); // [R3] [R7] [R10] [R11]
         out_d[p] = ctrl_q[p][aontpg_pkg::FLD_LEVEL] & ~oe_n_d[p]; // [R4] [R8]
         pull_d[p] = ctrl_q[p][aontpg_pkg::FLD_PULL] & ~pad_rst; // [R2] [R6]
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         out_q <= '0;
         oe_n_q <= '1;
         pull_q <= '0;
      end else begin
         out_q <= out_d;
         oe_n_q <= oe_n_d;
         pull_q <= pull_d;
      end
   end

   assign aon_pin_out = out_q;
   assign aon_pin_oe_n = oe_n_q;
   assign aon_pin_pullup = pull_q;

   // ------------------------------------------------------------
   // Assertions and cover points
   // ------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);

   a_bus_ack_pulse: assert property (req |=> ack_q ##1 !ack_q)
      else $error("Bus request was not answered by a one-cycle ack.");

   a_upper_zero: assert property (ack_q |-> wb_dat_o[aontpg_pkg::DATA_W-1:aontpg_pkg::PIN_STRIDE*PINS] == '0) // [R12]
      else $error("Upper register bits read non-zero.");

   a_pin_sync_delay: assert property (!$past(reset, 2) |-> pin_s == $past(aon_pin_in, 2)) // [R13]
      else $error("Pin status did not follow the pin two cycles late.");

   a_domain_clear: assert property (domain_rst |=> ctrl_q == '0) // [R9]
      else $error("Control bits survived an always-on supply failure.");

   a_pad_hold_off: assert property (pad_rst |=> aon_pin_oe_n == '1 && aon_pin_pullup == '0) // [R10] [R11]
      else $error("Pads were driven while the pad logic was in reset.");

   a_supply_fail_reset: assert property ((!io_supply_low_ok || !io_supply_high_ok) [*3] |=> pad_rst) // [R11]
      else $error("I/O supply failure did not reset the pad logic.");

   a_supply_good_release: assert property ((!reset && io_supply_low_ok && io_supply_high_ok) [*3] // [R10]
      |=> !pad_rst)
      else $error("Pad logic stayed in reset with both supplies good.");

   generate
      for (genvar p = 0; p < PINS; p++) begin : g_chk
         a_input_status: assert property (ack_q && $past(hit && !wb_we_i)
            |-> wb_dat_o[aontpg_pkg::PIN_STRIDE*p+aontpg_pkg::FLD_IN] == $past(pin_s[p])) // [R1] [R5]
            else $error("Input status bit does not match the synchronised pin.");

         a_pull_follow: assert property (wr_fire && !soft_rst ##1 !soft_rst
            |=> aon_pin_pullup[p] == $past(wb_dat_i[aontpg_pkg::PIN_STRIDE*p+aontpg_pkg::FLD_PULL], 2)) // [R2] [R6]
            else $error("Pull-up output does not follow the written bit.");

         a_drive_enable: assert property (wr_fire && !soft_rst ##1 !soft_rst
            |=> aon_pin_oe_n[p] == !$past(wb_dat_i[aontpg_pkg::PIN_STRIDE*p+aontpg_pkg::FLD_DRIVE], 2)) // [R3] [R7]
            else $error("Output enable does not follow the written bit.");

         a_drive_level: assert property (!aon_pin_oe_n[p]
            |-> aon_pin_out[p] == $past(ctrl_q[p][aontpg_pkg::FLD_LEVEL])) // [R4] [R8]
            else $error("Driven level differs from the stored level.");
      end
   endgenerate

   // ------------------------------------------------------------
   // Bus, supply and pad checks on the ports and on internal state
   // ------------------------------------------------------------
   a_ack_needs_request: assert property (wb_ack_o
      |-> $past(wb_cyc_i && wb_stb_i))
      else $error("Ack was given without a bus request.");

   a_ack_answers_request: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
      |=> wb_ack_o)
      else $error("Bus request was not answered in the next cycle.");

   a_ack_one_cycle: assert property (wb_ack_o
      |=> !wb_ack_o)
      else $error("Ack stood for more than one cycle.");

   a_idle_data_zero: assert property (!wb_ack_o
      |-> wb_dat_o == '0)
      else $error("Read data was non-zero outside an ack cycle.");

   a_unmapped_read_zero: assert property (wb_ack_o && $past(!hit && !wb_we_i) // [R12]
      |-> wb_dat_o == '0)
      else $error("Read of an unmapped address returned data.");

   a_unmapped_write_kept: assert property (req && wb_we_i && !hit && !soft_rst // [R12]
      |=> ctrl_q == $past(ctrl_q))
      else $error("Write to an unmapped address changed the control bits.");

   a_low_lane_gate: assert property (req && wb_we_i && !wb_sel_i[0] && !soft_rst
      |=> ctrl_q == $past(ctrl_q))
      else $error("Write without the low byte lane changed the control bits.");

   a_reset_write_drop: assert property (req && wb_we_i && soft_rst // [R9] [R10] [R11]
      |=> ctrl_q == '0)
      else $error("Write during a supply reset was stored.");

   a_pad_clear_ctrl: assert property (pad_rst // [R10] [R11]
      |=> ctrl_q == '0)
      else $error("Control bits survived an I/O supply reset.");

   a_low_supply_fail: assert property ((!io_supply_low_ok) [*3] // [R11]
      |=> pad_rst)
      else $error("Low I/O supply failure did not reset the pad logic.");

   a_high_supply_fail: assert property ((!io_supply_high_ok) [*3] // [R11]
      |=> pad_rst)
      else $error("High I/O supply failure did not reset the pad logic.");

   a_domain_fail_reset: assert property ((!aon_supply_ok) [*3] // [R9]
      |=> domain_rst)
      else $error("Always-on supply failure did not reset the domain.");

   a_domain_good_release: assert property ((!reset && aon_supply_ok) [*3] // [R9]
      |=> !domain_rst)
      else $error("Domain stayed in reset with its supply good.");

   generate
      for (genvar p = 0; p < PINS; p++) begin : g_port_chk
         a_ctrl_store: assert property (wr_fire && !soft_rst // [R2] [R3] [R4] [R6] [R7] [R8]
            |=> ctrl_q[p] == $past(wb_dat_i[aontpg_pkg::PIN_STRIDE*p +: aontpg_pkg::CTRL_W]))
            else $error("Control bits do not hold the written value.");

         a_ctrl_readback: assert property (wb_ack_o && $past(hit && !wb_we_i) // [R2] [R3] [R4] [R6] [R7] [R8]
            |-> wb_dat_o[aontpg_pkg::PIN_STRIDE*p +: aontpg_pkg::CTRL_W] == $past(ctrl_q[p]))
            else $error("Read data does not show the stored control bits.");

         a_undriven_low: assert property (aon_pin_oe_n[p] // [R4] [R8]
            |-> !aon_pin_out[p])
            else $error("Driven level is high on a pin that is not driven.");

         a_drive_tracks_ctrl: assert property (!pad_rst // [R3] [R7]
            |=> aon_pin_oe_n[p] == !$past(ctrl_q[p][aontpg_pkg::FLD_DRIVE]))
            else $error("Output enable does not follow the stored direction bit.");

         a_pull_tracks_ctrl: assert property (!pad_rst // [R2] [R6]
            |=> aon_pin_pullup[p] == $past(ctrl_q[p][aontpg_pkg::FLD_PULL]))
            else $error("Pull-up output does not follow the stored bit.");
      end
   endgenerate

   c_write_ctrl: cover property (wr_fire && !soft_rst);
   c_read_ctrl: cover property (req && !wb_we_i && hit ##1 ack_q);
   c_pad_reset: cover property (!pad_rst ##1 pad_rst);
   c_drive_high: cover property (!aon_pin_oe_n[0] && aon_pin_out[0]);
   c_supply_release: cover property (pad_rst ##1 !pad_rst);

endmodule

/* test/aontpg_pads.sv */
// External pad model that resolves the two pin levels seen by the block.
`timescale 1ns/100ps
module aontpg_pads (
   input wire logic clk,
   input wire logic [1:0] pin_out,
   input wire logic [1:0] pin_oe_n,
   input wire logic [1:0] pin_pullup,
   input wire logic [1:0] ext_en,
   input wire logic [1:0] ext_lvl,
   output logic [1:0] pin_level
);
   logic tog_q = 1'b0;
   always @(posedge clk) begin
      tog_q <= ~tog_q;
   end
   // A floating pin with no pull-up shows a level that changes every cycle.
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         if (!pin_oe_n[i]) begin
            pin_level[i] = pin_out[i];
         end else if (ext_en[i]) begin
            pin_level[i] = ext_lvl[i];
         end else if (pin_pullup[i]) begin
            pin_level[i] = 1'b1;
         end else begin
            pin_level[i] = tog_q;
         end
      end
   end
endmodule

/* test/test_aon_two_pin_gpio_control.sv */
// Self-checking testbench for the two-pin always-on pin control register.
`timescale 1ns/100ps
module test_aon_two_pin_gpio_control;
   typedef struct packed {logic [31:0] w; logic [1:0] en; logic [1:0] lvl;} aontpg_row_t;
   logic clk = 1'b0, reset = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
   logic [7:0] adr = 8'h00;
   logic [3:0] sel = 4'h0;
   logic [31:0] dat = 32'h0, rdat, q;
   logic [1:0] pin_in, pin_out, oe_n, pull, ext_en = 2'h0, ext_lvl = 2'h0;
   logic lo_ok = 1'b1, hi_ok = 1'b1, aon_ok = 1'b1;
   int num_errors = 0, checks_done = 0;
   aontpg_row_t rows [7] = '{'{32'hffffff77, 2'h0, 2'h0}, '{32'h00, 2'h3, 2'h2}, '{32'h22, 2'h0, 2'h0},
      '{32'h55, 2'h3, 2'h1}, '{32'h44, 2'h0, 2'h0}, '{32'h11, 2'h3, 2'h3}, '{32'hffffff00, 2'h3, 2'h0}};
   aontpg_top DUT (.clk(clk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .aon_pin_in(pin_in),
      .aon_pin_out(pin_out), .aon_pin_oe_n(oe_n), .aon_pin_pullup(pull), .io_supply_low_ok(lo_ok),
      .io_supply_high_ok(hi_ok), .aon_supply_ok(aon_ok));
   aontpg_pads pads (.clk(clk), .pin_out(pin_out), .pin_oe_n(oe_n), .pin_pullup(pull), .ext_en(ext_en),
      .ext_lvl(ext_lvl), .pin_level(pin_in));
   initial begin
      forever #20 clk = ~clk;
   end
   // ------------------------------------------------------------
   // Bus tasks and comparison
   // ------------------------------------------------------------
   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH at %0t: %s got %h expected %h", $time, msg, got, exp);
      end
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= s; dat <= d;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      q = rdat;
      if (n >= 20) check(32'h1, 32'h0, "no acknowledge");
      cyc <= 1'b0; stb <= 1'b0;
   endtask
   function automatic logic [31:0] exp_rd(input aontpg_row_t r);
      logic [31:0] e;
      e = {24'h0, 1'b0, r.w[6:4], 1'b0, r.w[2:0]};
      e[7] = r.w[5] ? r.w[4] : (r.en[1] ? r.lvl[1] : r.w[6]);
      e[3] = r.w[1] ? r.w[0] : (r.en[0] ? r.lvl[0] : r.w[2]);
      return e;
   endfunction
   task automatic final_report;
      $display("checks %0d mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   initial begin
      #200000;
      num_errors++;
      final_report();
   end
   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      repeat (6) @(posedge clk);
      check({30'h0, oe_n}, 32'h3, "reset drive enables");
      check({28'h0, pull, pin_out}, 32'h0, "reset pull-ups and levels");
      wb(1'b0, 8'h20, 4'hf, 32'h0);
      check(q & 32'hffffff77, 32'h0, "reset register value");
      $display("reset test done");
      foreach (rows[i]) begin
         ext_en <= rows[i].en; ext_lvl <= rows[i].lvl;
         wb(1'b1, 8'h20, 4'hf, rows[i].w);
         repeat (2) @(posedge clk);
         wb(1'b0, 8'h20, 4'hf, 32'h0);
         check(q, exp_rd(rows[i]), "register read");
         check({30'h0, oe_n}, {30'h0, ~rows[i].w[5], ~rows[i].w[1]}, "drive enables");
         check({30'h0, pin_out}, {30'h0, rows[i].w[5] & rows[i].w[4], rows[i].w[1] & rows[i].w[0]},
            "driven levels");
         check({30'h0, pull}, {30'h0, rows[i].w[6], rows[i].w[2]}, "pull-ups");
      end
      $display("row tests done");
      ext_en <= 2'h3; ext_lvl <= 2'h0;
      wb(1'b1, 8'h20, 4'hf, 32'h66);
      wb(1'b1, 8'h24, 4'hf, 32'h11);
      wb(1'b1, 8'h20, 4'he, 32'h11);
      wb(1'b0, 8'h24, 4'hf, 32'h0);
      check(q, 32'h0, "unmapped read");
      wb(1'b0, 8'h20, 4'hf, 32'h0);
      check(q, 32'h66, "ignored writes");
      lo_ok <= 1'b0;
      repeat (6) @(posedge clk);
      check({28'h0, oe_n, pull}, 32'hc, "pads released on low supply fail");
      wb(1'b1, 8'h20, 4'hf, 32'h77);
      lo_ok <= 1'b1;
      repeat (6) @(posedge clk);
      wb(1'b0, 8'h20, 4'hf, 32'h0);
      check(q, 32'h0, "pad logic reset after supply fail");
      wb(1'b1, 8'h20, 4'hf, 32'h22);
      hi_ok <= 1'b0;
      repeat (6) @(posedge clk);
      check({30'h0, oe_n}, 32'h3, "pads released on high supply fail");
      hi_ok <= 1'b1;
      repeat (6) @(posedge clk);
      wb(1'b1, 8'h20, 4'hf, 32'h44);
      aon_ok <= 1'b0;
      repeat (4) @(posedge clk);
      aon_ok <= 1'b1;
      repeat (6) @(posedge clk);
      wb(1'b0, 8'h20, 4'hf, 32'h0);
      check(q, 32'h0, "domain reset clears register");
      $display("supply tests done");
      final_report();
   end
endmodule
